// *** bench/ddr_phy_init_sequencer_tb_top.sv ***
// self-checking bench for the phy and controller bring-up sequencer
`timescale 1ns/1ps
`default_nettype none
module ddr_phy_init_sequencer_tb_top;
    localparam int unsigned P_PLL = 20;
    localparam int unsigned P_Z = 4;
    localparam int unsigned P_D = 4;
    localparam int unsigned P_R = 3;
    localparam int unsigned P_M = 8;
    localparam int unsigned P_TRAS_MAX = 9000; // plain row-active limit
    logic clk, rst, trig_wr, sw_done, init_en, cfg_wr;
    logic [31:0] trig_data, cfg_wdata, cfg_rdata;
    logic [1:0] cfg_idx, operating_mode;
    logic done, ack, dfi, mem_ok, rst_act;
    logic first_done, first_rst, first_dfi;
    int fails, total_checks, n;
    logic [31:0] tv [7];
    int tmin [7];
    int tmax [7];
    logic [31:0] cw [4];

    ddrps_host_model host (.clk(clk), .trig_wr(trig_wr),
        .trig_data(trig_data), .sw_done(sw_done), .init_en(init_en),
        .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata));
    ddr_phy_init_sequencer #(.PLL_CYCLES(P_PLL), .ZCAL_CYCLES(P_Z),
        .DCAL_CYCLES(P_D), .PHYRST_CYCLES(P_R), .MEMINIT_CYCLES(P_M)) uut (
        .clk(clk), .rst(rst), .trig_wr(trig_wr),
        .phy_init_trigger_reg(trig_data), .software_done_bit(sw_done),
        .init_complete_enable_bit(init_en), .cfg_wr(cfg_wr),
        .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
        .phy_init_done_flag(done), .software_done_ack(ack),
        .dfi_init_complete(dfi), .operating_mode(operating_mode),
        .mem_access_ok(mem_ok), .phy_reset_active(rst_act),
        .cfg_rdata(cfg_rdata));

    // verdict and end of run
    task automatic summarize();
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // single-bit comparison
    task automatic check_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, e, s);
        end
    endtask
    // word comparison
    task automatic check_vec(input string nm, input logic [31:0] e,
                             input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // cycle count within a window
    task automatic check_cnt(input string nm, input int lo, input int hi,
                             input int s);
        total_checks++;
        if (s < lo || s > hi) begin
            fails++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                     nm, lo, hi, s);
        end
    endtask
    // bounded wait for done flag (0) or normal mode (1)
    task automatic wait_for(input int sel, output int cnt);
        logic hit;
        cnt = 0;
        for (int i = 1; i <= 300; i++) begin
            @(posedge clk);
            #1;
            if (i == 1) begin
                first_done = done;
                first_rst = rst_act;
                first_dfi = dfi;
            end
            hit = (sel == 0) ? done
                : (operating_mode === ddrps_pkg::MODE_NORMAL);
            if (hit === 1'b1) begin
                cnt = i;
                break;
            end
        end
        if (cnt == 0) begin
            check_cnt("wait_cycles", 1, 300, cnt);
            summarize();
        end
    endtask
    // trigger write then timed wait for init-done
    task automatic measure(input logic [31:0] v, input int lo, input int hi);
        int c;
        logic no_fn;
        // a trigger that starts no function must report done at once
        no_fn = ((v & 32'h0000_0072) == 32'h0000_0000);
        host.write_trigger(v);
        wait_for(0, c);
        check_cnt("done_cycles", lo, hi, c);
        check_bit("done_first", no_fn, first_done);
        check_bit("reset_active", v[6], first_rst);
        check_bit("dfi_complete", v[18], first_dfi);
    endtask
    // reset held 12 cycles, then all outputs low
    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check_bit("done_rst", 1'b0, done);
        check_bit("ack_rst", 1'b0, ack);
        check_bit("dfi_rst", 1'b0, dfi);
        check_bit("mem_ok_rst", 1'b0, mem_ok);
        check_bit("rst_act_rst", 1'b0, rst_act);
        check_vec("mode_rst", 32'h0, {30'h0, operating_mode});
        check_vec("rdata_rst", 32'h0, cfg_rdata);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        fails = 0;
        total_checks = 0;
        tv = '{32'h0004_0001, 32'h0000_0073, 32'h0000_0003, 32'h0000_0011,
               32'h0000_0021, 32'h0000_0041, 32'h0000_0031};
        tmin = '{1, P_PLL + P_D, P_Z, P_PLL, P_D, P_R, P_PLL + P_D};
        tmax = '{4, P_PLL + P_D + 6, P_Z + 6, P_PLL + 6, P_D + 6, P_R + 6,
                 P_PLL + P_D + 6};
        cw = '{P_TRAS_MAX - 400, 32'h0000_0001, 32'hA5C3_0F12, 32'h5A3C_F0ED};
        do_reset();
        // no function, each single function, pll with delay cal and the full mix; dfi set then cleared
        for (int k = 0; k < 7; k++) begin
            measure(tv[k], tmin[k], tmax[k]);
        end
        // write without init bit is ignored
        host.write_trigger(32'h0000_0072);
        repeat (3) @(posedge clk);
        #1;
        check_bit("done_after_ignored", 1'b1, done);
        // second write mid-sequence restarts all timers
        host.write_trigger(32'h0000_0073);
        repeat (10) @(posedge clk);
        measure(32'h0000_0073, P_PLL + P_D, P_PLL + P_D + 6);
        // timing words written while the phy is busy
        host.write_trigger(32'h0000_0073);
        for (int k = 0; k < 4; k++) begin
            host.write_cfg(k[1:0], cw[k]);
        end
        #1;
        check_bit("done_busy", 1'b0, done);
        for (int k = 0; k < 4; k++) begin
            host.set_idx(k[1:0]);
            repeat (2) @(posedge clk);
            #1;
            check_vec("cfg_word", cw[k], cfg_rdata);
        end
        wait_for(0, n);
        // controller waits for dfi complete; enable change ignored
        host.set_swdone(1'b0);
        host.set_enable(1'b1);
        host.set_swdone(1'b1);
        @(posedge clk);
        #1;
        check_bit("ack_set", 1'b1, ack);
        host.set_enable(1'b0);
        repeat (30) @(posedge clk);
        #1;
        check_vec("mode_wait", 32'h0, {30'h0, operating_mode});
        check_bit("mem_ok_wait", 1'b0, mem_ok);
        host.write_trigger(32'h0004_0001);
        wait_for(1, n);
        check_cnt("meminit_cycles", P_M, P_M + 6, n);
        check_bit("dfi_cycle1", 1'b1, first_dfi);
        check_bit("mem_ok_normal", 1'b1, mem_ok);
        // enable clear skips dfi wait; no access without dfi
        host.set_swdone(1'b0);
        do_reset();
        host.set_swdone(1'b1);
        wait_for(1, n);
        check_cnt("meminit_nowait", P_M, P_M + 6, n);
        check_bit("mem_ok_nodfi", 1'b0, mem_ok);
        host.set_swdone(1'b0);
        @(posedge clk);
        #1;
        check_bit("ack_clear", 1'b0, ack);
        check_vec("mode_final", {30'h0, ddrps_pkg::MODE_NORMAL},
                  {30'h0, operating_mode});
        summarize();
    end
endmodule
`default_nettype wire

// *** bench/ddrps_host_model.sv ***
// host-software model driving the bring-up sequencer's inputs
`timescale 1ns/1ps
`default_nettype none
module ddrps_host_model (
    input wire logic clk,
    output logic trig_wr,
    output logic [31:0] trig_data,
    output logic sw_done,
    output logic init_en,
    output logic cfg_wr,
    output logic [ddrps_pkg::CFG_IDX_W-1:0] cfg_idx,
    output logic [31:0] cfg_wdata
);
    // idle, stable settings before any reset release
    initial begin
        trig_wr = 1'b0;
        trig_data = 32'h0000_0000;
        sw_done = 1'b0;
        init_en = 1'b0;
        cfg_wr = 1'b0;
        cfg_idx = 2'h0;
        cfg_wdata = 32'h0000_0000;
    end
    // one-cycle trigger write, init bit chosen by caller
    task automatic write_trigger(input logic [31:0] v);
        @(posedge clk);
        trig_wr <= 1'b1;
        trig_data <= v;
        @(posedge clk);
        trig_wr <= 1'b0;
    endtask
    // timing and training word write, allowed while phy is busy
    task automatic write_cfg(input logic [1:0] i,
                             input logic [31:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_idx <= i;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    // software-done level; cleared before quasi-static changes
    task automatic set_swdone(input logic v);
        @(posedge clk);
        sw_done <= v;
    endtask
    // init-complete-enable level
    task automatic set_enable(input logic v);
        @(posedge clk);
        init_en <= v;
    endtask
    // read index select
    task automatic set_idx(input logic [1:0] i);
        @(posedge clk);
        cfg_idx <= i;
    endtask
endmodule
`default_nettype wire

// *** hdl/ddr_phy_init_sequencer.sv ***
// phy and controller bring-up sequencer with software handshakes
`timescale 1ns/1ps
`default_nettype none
module ddr_phy_init_sequencer #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned PLL_CYCLES = ddrps_pkg::PLL_TOTAL_CYCLES,
    parameter int unsigned ZCAL_CYCLES = ddrps_pkg::ZCAL_CYCLES,
    parameter int unsigned DCAL_CYCLES = ddrps_pkg::DCAL_CYCLES,
    parameter int unsigned PHYRST_CYCLES = ddrps_pkg::PHYRST_CYCLES,
    parameter int unsigned MEMINIT_CYCLES = ddrps_pkg::MEMINIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic trig_wr,
    input wire logic [31:0] phy_init_trigger_reg,
    input wire logic software_done_bit,
    input wire logic init_complete_enable_bit,
    input wire logic cfg_wr,
    input wire logic [ddrps_pkg::CFG_IDX_W-1:0] cfg_idx,
    input wire logic [31:0] cfg_wdata,
    output logic phy_init_done_flag,
    output logic software_done_ack,
    output logic dfi_init_complete,
    output logic [1:0] operating_mode,
    output logic mem_access_ok,
    output logic phy_reset_active,
    output logic [31:0] cfg_rdata
);
    initial begin
        if (CNT_W < 2 || CNT_W > 31) $error("CNT_W out of range");
        if (PLL_CYCLES < 1 || PLL_CYCLES >= (1 << CNT_W))
            $error("PLL_CYCLES does not fit CNT_W");
        if (ZCAL_CYCLES < 1 || ZCAL_CYCLES >= (1 << CNT_W))
            $error("ZCAL_CYCLES does not fit CNT_W");
        if (DCAL_CYCLES < 1 || DCAL_CYCLES >= (1 << CNT_W))
            $error("DCAL_CYCLES does not fit CNT_W");
        if (PHYRST_CYCLES < 1 || PHYRST_CYCLES >= (1 << CNT_W))
            $error("PHYRST_CYCLES does not fit CNT_W");
        if (MEMINIT_CYCLES < 1 || MEMINIT_CYCLES >= (1 << CNT_W))
            $error("MEMINIT_CYCLES does not fit CNT_W");
    end

    // load value for each function slot
    function automatic logic [CNT_W-1:0] fn_load(input int unsigned i);
        int unsigned v;
        case (i)
            ddrps_pkg::FN_PLL: v = PLL_CYCLES;
            ddrps_pkg::FN_ZCAL: v = ZCAL_CYCLES;
            ddrps_pkg::FN_DCAL: v = DCAL_CYCLES;
            default: v = PHYRST_CYCLES;
        endcase
        return v[CNT_W-1:0];
    endfunction

    // a trigger write that carries the init bit
    function automatic logic is_init_write(input logic wr,
                                           input logic [31:0] d);
        return wr && d[ddrps_pkg::TRIG_INIT_BIT];
    endfunction

    logic init_wr;
    logic [ddrps_pkg::FN_COUNT-1:0] fn_start;
    logic [ddrps_pkg::FN_COUNT-1:0] fn_busy;
    logic [ddrps_pkg::FN_COUNT-1:0] fn_done;
    logic dcal_pending;
    logic next_dcal_pending;
    logic init_running;
    logic next_init_running;
    logic next_phy_init_done_flag;
    logic next_dfi_init_complete;
    logic next_phy_reset_active;

    assign init_wr = is_init_write(trig_wr, phy_init_trigger_reg);

    // start pll, impedance and reset at once; delay cal after pll
    always_comb begin
        fn_start = '0;
        fn_start[ddrps_pkg::FN_PLL] = init_wr &&
            phy_init_trigger_reg[ddrps_pkg::TRIG_PLL_BIT];
        fn_start[ddrps_pkg::FN_ZCAL] = init_wr &&
            phy_init_trigger_reg[ddrps_pkg::TRIG_ZCAL_BIT];
        fn_start[ddrps_pkg::FN_PHYRST] = init_wr &&
            phy_init_trigger_reg[ddrps_pkg::TRIG_PHYRST_BIT];
        fn_start[ddrps_pkg::FN_DCAL] = dcal_pending &&
            !fn_busy[ddrps_pkg::FN_PLL];
    end

    // timer bank, one per phy function
    genvar g;
    generate
        for (g = 0; g < ddrps_pkg::FN_COUNT; g++) begin : g_fn
            ddrps_func_timer #(.CNT_W(CNT_W)) u_timer (
                .clk(clk),
                .rst(rst),
                .start(fn_start[g]),
                .load(fn_load(g)),
                .busy(fn_busy[g]),
                .done(fn_done[g])
            );
        end
    endgenerate

    // init-done flag and dfi init complete tracking
    always_comb begin
        next_dcal_pending = dcal_pending;
        next_init_running = init_running;
        next_phy_init_done_flag = phy_init_done_flag;
        next_dfi_init_complete = dfi_init_complete;
        next_phy_reset_active = fn_busy[ddrps_pkg::FN_PHYRST] ||
            fn_start[ddrps_pkg::FN_PHYRST];
        if (fn_start[ddrps_pkg::FN_DCAL]) begin
            next_dcal_pending = 1'b0;
        end
        if (init_wr) begin
            next_init_running = 1'b1;
            next_phy_init_done_flag = 1'b0;
            next_dcal_pending =
                phy_init_trigger_reg[ddrps_pkg::TRIG_DCAL_BIT];
            // handing memory init to the controller completes dfi init
            next_dfi_init_complete =
                phy_init_trigger_reg[ddrps_pkg::TRIG_CTLDINIT_BIT];
        end else if (init_running && fn_busy == '0 && !dcal_pending &&
                     fn_start == '0) begin
            next_init_running = 1'b0;
            next_phy_init_done_flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dcal_pending <= 1'b0;
            init_running <= 1'b0;
            phy_init_done_flag <= 1'b0;
            dfi_init_complete <= 1'b0;
            phy_reset_active <= 1'b0;
        end else begin
            dcal_pending <= next_dcal_pending;
            init_running <= next_init_running;
            phy_init_done_flag <= next_phy_init_done_flag;
            dfi_init_complete <= next_dfi_init_complete;
            phy_reset_active <= next_phy_reset_active;
        end
    end

    // timing and training words, writable at any time
    logic [31:0] cfg_mem [ddrps_pkg::CFG_WORDS];
    logic [31:0] next_cfg_rdata;

    always_comb begin
        next_cfg_rdata = cfg_mem[cfg_idx];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < ddrps_pkg::CFG_WORDS; i++) begin
                cfg_mem[i] <= 32'h0000_0000;
            end
            cfg_rdata <= 32'h0000_0000;
        end else begin
            if (cfg_wr) begin
                cfg_mem[cfg_idx] <= cfg_wdata;
            end
            cfg_rdata <= next_cfg_rdata;
        end
    end

    // controller: software-done handshake and memory init
    ddrps_pkg::ddrps_ctl_state_t state;
    ddrps_pkg::ddrps_ctl_state_t next_state;
    logic en_latched;
    logic next_en_latched;
    logic next_software_done_ack;
    logic [CNT_W-1:0] mcnt;
    logic [CNT_W-1:0] next_mcnt;
    logic [1:0] next_operating_mode;
    logic next_mem_access_ok;
    logic ack_rise;

    assign ack_rise = software_done_bit && !software_done_ack;

    always_comb begin
        next_state = state;
        next_mcnt = mcnt;
        next_en_latched = en_latched;
        next_software_done_ack = software_done_bit;
        // quasi-static setting only taken while software-done is low
        if (!software_done_bit) begin
            next_en_latched = init_complete_enable_bit;
        end
        case (state)
            ddrps_pkg::DDRPS_CTL_IDLE: begin
                if (ack_rise) begin
                    next_state = ddrps_pkg::DDRPS_CTL_WAIT_DFI;
                end
            end
            ddrps_pkg::DDRPS_CTL_WAIT_DFI: begin
                if (!en_latched || dfi_init_complete) begin
                    next_state = ddrps_pkg::DDRPS_CTL_MEMINIT;
                    next_mcnt = MEMINIT_CYCLES[CNT_W-1:0];
                end
            end
            ddrps_pkg::DDRPS_CTL_MEMINIT: begin
                if (mcnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    next_state = ddrps_pkg::DDRPS_CTL_NORMAL;
                    next_mcnt = '0;
                end else begin
                    next_mcnt = mcnt - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            ddrps_pkg::DDRPS_CTL_NORMAL: begin
                next_state = ddrps_pkg::DDRPS_CTL_NORMAL;
            end
            default: begin
                next_state = ddrps_pkg::DDRPS_CTL_IDLE;
            end
        endcase
        next_operating_mode = (next_state == ddrps_pkg::DDRPS_CTL_NORMAL) ?
            ddrps_pkg::MODE_NORMAL : ddrps_pkg::MODE_INIT;
        // access only once dfi and memory init are both done
        next_mem_access_ok = (next_state == ddrps_pkg::DDRPS_CTL_NORMAL) &&
            dfi_init_complete;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ddrps_pkg::DDRPS_CTL_IDLE;
            mcnt <= '0;
            en_latched <= 1'b0;
            software_done_ack <= 1'b0;
            operating_mode <= ddrps_pkg::MODE_INIT;
            mem_access_ok <= 1'b0;
        end else begin
            state <= next_state;
            mcnt <= next_mcnt;
            en_latched <= next_en_latched;
            software_done_ack <= next_software_done_ack;
            operating_mode <= next_operating_mode;
            mem_access_ok <= next_mem_access_ok;
        end
    end

    // checks
    property p_trig_clears_done;
        @(posedge clk) disable iff (rst) init_wr |=> !phy_init_done_flag;
    endproperty
    a_trig_clears_done: assert property (p_trig_clears_done)
        else $error("done flag not cleared by trigger");

    property p_done_idle;
        @(posedge clk) disable iff (rst)
            $rose(phy_init_done_flag) |-> fn_busy == '0 && !dcal_pending;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("done flag set while a function runs");

    property p_dcal_after_pll;
        @(posedge clk) disable iff (rst)
            fn_busy[ddrps_pkg::FN_DCAL] |-> !fn_busy[ddrps_pkg::FN_PLL];
    endproperty
    a_dcal_after_pll: assert property (p_dcal_after_pll)
        else $error("delay cal overlaps pll init");

    property p_full_trigger;
        @(posedge clk) disable iff (rst)
            trig_wr && phy_init_trigger_reg == ddrps_pkg::TRIG_FULL_PHY_INIT
            |=> fn_busy[ddrps_pkg::FN_PLL] && fn_busy[ddrps_pkg::FN_ZCAL]
                && phy_reset_active && dcal_pending;
    endproperty
    a_full_trigger: assert property (p_full_trigger)
        else $error("full trigger did not start all functions");

    property p_ack_follows;
        @(posedge clk) disable iff (rst)
            software_done_bit |=> software_done_ack;
    endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("software-done acknowledge missing");

    property p_wait_dfi;
        @(posedge clk) disable iff (rst)
            state == ddrps_pkg::DDRPS_CTL_WAIT_DFI && en_latched &&
            !dfi_init_complete |=> state == ddrps_pkg::DDRPS_CTL_WAIT_DFI;
    endproperty
    a_wait_dfi: assert property (p_wait_dfi)
        else $error("memory init started before dfi init complete");

    property p_access_gated;
        @(posedge clk) disable iff (rst)
            mem_access_ok |-> operating_mode == ddrps_pkg::MODE_NORMAL &&
            $past(dfi_init_complete);
    endproperty
    a_access_gated: assert property (p_access_gated)
        else $error("memory access allowed before init");

    property p_normal_report;
        @(posedge clk) disable iff (rst)
            state == ddrps_pkg::DDRPS_CTL_MEMINIT &&
            mcnt == {{(CNT_W-1){1'b0}}, 1'b1}
            |=> operating_mode == ddrps_pkg::MODE_NORMAL;
    endproperty
    a_normal_report: assert property (p_normal_report)
        else $error("normal mode not reported after memory init");

    property p_cfg_accept;
        @(posedge clk) disable iff (rst)
            cfg_wr ##1 !cfg_wr && cfg_idx == $past(cfg_idx)
            |=> cfg_rdata == $past(cfg_wdata, 2);
    endproperty
    a_cfg_accept: assert property (p_cfg_accept)
        else $error("configuration write not kept");

    c_full_init: cover property (@(posedge clk) disable iff (rst)
        $rose(phy_init_done_flag));
    c_ack: cover property (@(posedge clk) disable iff (rst)
        $rose(software_done_ack));
    c_normal: cover property (@(posedge clk) disable iff (rst)
        $rose(mem_access_ok));
endmodule
`default_nettype wire

// *** hdl/ddrps_func_timer.sv ***
// one phy bring-up function modelled as a load-and-count-down timer
`timescale 1ns/1ps
`default_nettype none
module ddrps_func_timer #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [CNT_W-1:0] load,
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_busy;
    logic next_done;

    // count down from load, pulse done as busy drops after the last count
    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (start) begin
            next_cnt = load;
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_cnt = '0;
            end else begin
                next_cnt = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// *** hdl/ddrps_pkg.sv ***
// shared constants for the phy and controller bring-up sequencer
package ddrps_pkg;
    // trigger register bit positions
    localparam int unsigned TRIG_INIT_BIT = 0;
    localparam int unsigned TRIG_ZCAL_BIT = 1;
    localparam int unsigned TRIG_PLL_BIT = 4;
    localparam int unsigned TRIG_DCAL_BIT = 5;
    localparam int unsigned TRIG_PHYRST_BIT = 6;
    localparam int unsigned TRIG_CTLDINIT_BIT = 18;
    // single-write full phy bring-up value
    localparam logic [31:0] TRIG_FULL_PHY_INIT = 32'h0000_0073;
    // function slots in the timer bank
    localparam int unsigned FN_PLL = 0;
    localparam int unsigned FN_ZCAL = 1;
    localparam int unsigned FN_DCAL = 2;
    localparam int unsigned FN_PHYRST = 3;
    localparam int unsigned FN_COUNT = 4;
    // pll timing parts and the other function and memory init lengths, in clock cycles
    localparam int unsigned PLL_PD_CYCLES = 500;
    localparam int unsigned PLL_GS_CYCLES = 2000;
    localparam int unsigned PLL_LOCK_CYCLES = 12500;
    localparam int unsigned PLL_RST_CYCLES = 4500;
    localparam int unsigned PLL_TOTAL_CYCLES = PLL_PD_CYCLES +
        PLL_GS_CYCLES + PLL_LOCK_CYCLES + PLL_RST_CYCLES;
    localparam int unsigned ZCAL_CYCLES = 64;
    localparam int unsigned DCAL_CYCLES = 256;
    localparam int unsigned PHYRST_CYCLES = 32;
    localparam int unsigned MEMINIT_CYCLES = 1024;
    // operating mode status codes
    localparam logic [1:0] MODE_INIT = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    // controller states
    typedef enum logic [1:0] {
        DDRPS_CTL_IDLE = 2'b00,
        DDRPS_CTL_WAIT_DFI = 2'b01,
        DDRPS_CTL_MEMINIT = 2'b10,
        DDRPS_CTL_NORMAL = 2'b11
    } ddrps_ctl_state_t;
    // number of timing/training configuration words
    localparam int unsigned CFG_WORDS = 4;
    localparam int unsigned CFG_IDX_W = 2;
endpackage
